// File: logic/add_shifted_and_minus_one_extend.sv
// Contract
// - shifted add: immediate over sixteen zeros plus base
// - shifted add: base field zero means value zero
// - shifted add leaves all flags alone
// - 64-bit mode sign-extends bit 31 upward
// - decode minus-one add fields and opcodes
// - minus-one add: source plus carry plus ones
// - minus-one add always updates carry
// - overflow enable updates overflow and summary
// - record bit writes condition field 0
// - overflow and compare judged on 32 bits
`timescale 1ns/1ps
module add_shifted_and_minus_one_extend (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,

  // Instruction issue from the decoder
  input wire logic instr_valid,
  input wire logic [alu_pkg::WORD_W-1:0] instr_word,

  // Register access port
  input wire logic [alu_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [alu_pkg::DATA_W-1:0] bus_wdata,
  input wire logic bus_we,
  input wire logic bus_re,
  output logic [alu_pkg::DATA_W-1:0] bus_rdata,

  // Writeback report
  output logic wb_valid,
  output logic [alu_pkg::IDX_W-1:0] wb_index,
  output logic [alu_pkg::DATA_W-1:0] wb_data,

  // Flags and interrupt
  output alu_pkg::flags_t flags,
  output logic irq
);

  // ----------------------------------------
  // State
  // ----------------------------------------

  logic [alu_pkg::DATA_W-1:0] gpr_reg [alu_pkg::GPR_N];
  alu_pkg::flags_t flags_reg;
  alu_pkg::flags_t flags_next;
  logic mode_reg;
  logic [alu_pkg::EV_W-1:0] status_reg;
  logic [alu_pkg::EV_W-1:0] status_next;
  logic [alu_pkg::EV_W-1:0] mask_reg;
  logic irq_reg;
  logic [alu_pkg::DATA_W-1:0] rdata_reg;
  logic [alu_pkg::DATA_W-1:0] rdata_next;
  logic wb_valid_reg;
  logic [alu_pkg::IDX_W-1:0] wb_index_reg;
  logic [alu_pkg::DATA_W-1:0] wb_data_reg;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------

  // Register window holding the general registers
  function automatic logic is_gpr(input logic [alu_pkg::ADDR_W-1:0] a);
    is_gpr = (a <= alu_pkg::REG_GPR_LAST);
  endfunction

  // ----------------------------------------
  // Decode
  // ----------------------------------------

  alu_pkg::instr_fields_t fld;
  wire logic [alu_pkg::HALF_W-1:0] imm_field;
  wire logic is_shift;
  wire logic is_minus_one;
  wire logic illegal;

  assign fld = alu_pkg::instr_fields_t'(instr_word);
  // Immediate spans the low half of the word
  assign imm_field = {fld.spare, fld.oe, fld.xo, fld.record_bit};
  // Both spellings share one encoding, so one decode serves
  assign is_shift = instr_valid & (fld.primary == alu_pkg::OP_ADD_SHIFTED);
  assign is_minus_one = instr_valid & (fld.primary == alu_pkg::OP_EXTENDED)
                        & (fld.xo == alu_pkg::XO_ADD_MINUS_ONE);
  // Anything else is not ours; flagged, no state change
  assign illegal = instr_valid & ~is_shift & ~is_minus_one;

  // ----------------------------------------
  // Operand read
  // ----------------------------------------

  wire logic [alu_pkg::DATA_W-1:0] base_val;
  assign base_val = gpr_reg[fld.base_reg_field];

  // ----------------------------------------
  // Shifted-immediate add
  // ----------------------------------------

  wire logic [alu_pkg::WORD_W-1:0] imm_shifted;
  wire logic [alu_pkg::DATA_W-1:0] imm_wide;
  wire logic [alu_pkg::DATA_W-1:0] shift_base;
  wire logic [alu_pkg::DATA_W-1:0] shift_sum;
  wire logic [alu_pkg::DATA_W-1:0] shift_result;

  assign imm_shifted = {imm_field, alu_pkg::LOW_HALF_ZERO};
  // Signed in 64-bit mode; plain in 32-bit mode
  assign imm_wide = mode_reg ? {{alu_pkg::WORD_W{imm_shifted[alu_pkg::WORD_W-1]}}, imm_shifted}
                             : {alu_pkg::WORD_ZERO, imm_shifted};
  assign shift_base = (fld.base_reg_field == alu_pkg::ZERO_REG) ? alu_pkg::DATA_ZERO
                                                                : base_val;
  assign shift_sum = shift_base + imm_wide;
  // Upper word cleared in 32-bit mode so stale bits never leak
  assign shift_result = mode_reg ? shift_sum
                                 : {alu_pkg::WORD_ZERO, shift_sum[alu_pkg::WORD_W-1:0]};

  // ----------------------------------------
  // Minus-one extended add
  // ----------------------------------------

  wire logic [alu_pkg::DATA_W:0] m1_sum_wide;
  wire logic [alu_pkg::WORD_W:0] m1_sum_word;
  wire logic [alu_pkg::WORD_W-1:0] m1_word;
  wire logic [alu_pkg::DATA_W-1:0] m1_result;
  wire logic m1_carry;
  wire logic m1_overflow;
  wire logic so_after;
  alu_pkg::cr0_t cr0_new;

  assign m1_sum_wide = {1'b0, base_val} + {alu_pkg::DATA_ZERO, flags_reg.carry_flag}
                       + {1'b0, alu_pkg::DATA_ONES};
  assign m1_sum_word = {1'b0, base_val[alu_pkg::WORD_W-1:0]}
                       + {alu_pkg::WORD_ZERO, flags_reg.carry_flag}
                       + {1'b0, alu_pkg::WORD_ONES};
  assign m1_word = m1_sum_word[alu_pkg::WORD_W-1:0];
  assign m1_result = mode_reg ? m1_sum_wide[alu_pkg::DATA_W-1:0]
                              : {alu_pkg::WORD_ZERO, m1_word};
  // Carry taken at the width of the active mode
  assign m1_carry = mode_reg ? m1_sum_wide[alu_pkg::DATA_W] : m1_sum_word[alu_pkg::WORD_W];
  // Adding all-ones overflows only when a negative turns positive
  assign m1_overflow = base_val[alu_pkg::WORD_W-1] & ~m1_word[alu_pkg::WORD_W-1];
  // Summary can only be set here, never cleared
  assign so_after = flags_reg.summary_overflow | (fld.oe & m1_overflow);
  // Compare of the low word as signed
  assign cr0_new.negative_flag = m1_word[alu_pkg::WORD_W-1];
  assign cr0_new.positive_flag = ~m1_word[alu_pkg::WORD_W-1]
                                 & (m1_word != alu_pkg::WORD_ZERO);
  assign cr0_new.zero_flag = (m1_word == alu_pkg::WORD_ZERO);
  assign cr0_new.so_copy = so_after;

  // ----------------------------------------
  // Register port decode
  // ----------------------------------------

  wire logic hit_flags;
  wire logic hit_status;
  wire logic hit_mask;
  wire logic hit_mode;
  wire logic bus_flags_we;
  wire logic status_we;
  wire logic mask_we;
  wire logic mode_we;

  // One compare per word, shared by the write side and the read mux
  assign hit_flags = (bus_addr == alu_pkg::REG_FLAGS);
  assign hit_status = (bus_addr == alu_pkg::REG_IRQ_STATUS);
  assign hit_mask = (bus_addr == alu_pkg::REG_IRQ_MASK);
  assign hit_mode = (bus_addr == alu_pkg::REG_MODE);
  // Only writes move state; a read strobe never disturbs anything
  assign bus_flags_we = bus_we & hit_flags;
  assign status_we = bus_we & hit_status;
  assign mask_we = bus_we & hit_mask;
  assign mode_we = bus_we & hit_mode;

  // ----------------------------------------
  // Flag merge
  // ----------------------------------------

  // Minus-one add beats a software write in the same cycle;
  // the shifted add takes no branch here, so flags hold unless software writes them
  always_comb begin
    flags_next = flags_reg;
    if (is_minus_one) begin
      flags_next.carry_flag = m1_carry;
      if (fld.oe) begin
        flags_next.overflow_flag = m1_overflow;
        flags_next.summary_overflow = so_after;
      end
      if (fld.record_bit) begin
        flags_next.cr0 = cr0_new;
      end
    end else if (bus_flags_we) begin
      flags_next = alu_pkg::flags_t'(bus_wdata[$bits(alu_pkg::flags_t)-1:0]);
    end
  end

  // ----------------------------------------
  // Writeback select
  // ----------------------------------------

  wire logic do_write;
  wire logic [alu_pkg::DATA_W-1:0] result;
  wire logic bus_gpr_we;

  assign do_write = is_shift | is_minus_one;
  assign result = is_shift ? shift_result : m1_result;
  assign bus_gpr_we = bus_we & is_gpr(bus_addr);

  // ----------------------------------------
  // Interrupt events
  // ----------------------------------------

  wire logic [alu_pkg::EV_W-1:0] events;
  wire logic [alu_pkg::EV_W-1:0] status_clear;

  assign events[alu_pkg::EV_OVERFLOW] = is_minus_one & fld.oe & m1_overflow;
  assign events[alu_pkg::EV_ILLEGAL] = illegal;
  assign status_clear = status_we
                        ? bus_wdata[alu_pkg::EV_W-1:0] : alu_pkg::EV_RESET;
  // Set wins over a clear in the same cycle
  assign status_next = (status_reg & ~status_clear) | events;

  // ----------------------------------------
  // Register read mux
  // ----------------------------------------

  wire logic [alu_pkg::DATA_W-1:0] read_word;
  assign read_word =
    is_gpr(bus_addr) ? gpr_reg[bus_addr[alu_pkg::IDX_W-1:0]] :
    hit_flags ? {{(alu_pkg::DATA_W-$bits(alu_pkg::flags_t)){1'b0}}, flags_reg} :
    hit_status ? {{(alu_pkg::DATA_W-alu_pkg::EV_W){1'b0}}, status_reg} :
    hit_mask ? {{(alu_pkg::DATA_W-alu_pkg::EV_W){1'b0}}, mask_reg} :
    hit_mode ? {alu_pkg::DATA_ZERO[alu_pkg::DATA_W-1:1], mode_reg} :
    alu_pkg::DATA_ZERO;
  // Data only in the cycle after the strobe, zero otherwise
  assign rdata_next = bus_re ? read_word : alu_pkg::DATA_ZERO;

  // ----------------------------------------
  // General registers
  // ----------------------------------------

  // Instruction writeback overrides a software write to the same index
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < alu_pkg::GPR_N; i++) begin
        gpr_reg[i] <= alu_pkg::DATA_ZERO;
      end
    end else begin
      if (bus_gpr_we) begin
        gpr_reg[bus_addr[alu_pkg::IDX_W-1:0]] <= bus_wdata;
      end
      if (do_write) begin
        gpr_reg[fld.target_reg_field] <= result;
      end
    end
  end

  // ----------------------------------------
  // Flags, mode, interrupt state
  // ----------------------------------------

  // Mode is software-set; flips take effect for the next issue
  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= alu_pkg::FLAGS_RESET;
      mode_reg <= alu_pkg::MODE_RESET;
      status_reg <= alu_pkg::EV_RESET;
      mask_reg <= alu_pkg::EV_RESET;
      irq_reg <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      status_reg <= status_next;
      irq_reg <= |(status_next & mask_reg);
      if (mode_we) begin
        mode_reg <= bus_wdata[0];
      end
      if (mask_we) begin
        mask_reg <= bus_wdata[alu_pkg::EV_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= alu_pkg::DATA_ZERO;
      wb_valid_reg <= 1'b0;
      wb_index_reg <= alu_pkg::ZERO_REG;
      wb_data_reg <= alu_pkg::DATA_ZERO;
    end else begin
      rdata_reg <= rdata_next;
      wb_valid_reg <= do_write;
      wb_index_reg <= do_write ? fld.target_reg_field : alu_pkg::ZERO_REG;
      wb_data_reg <= do_write ? result : alu_pkg::DATA_ZERO;
    end
  end

  assign bus_rdata = rdata_reg;
  assign wb_valid = wb_valid_reg;
  assign wb_index = wb_index_reg;
  assign wb_data = wb_data_reg;
  assign flags = flags_reg;
  assign irq = irq_reg;

endmodule

// File: logic/alu_pkg.sv
package alu_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int unsigned DATA_W = 64;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned GPR_N = 32;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned EV_W = 2;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [5:0] OP_ADD_SHIFTED = 6'h0f;
  localparam logic [5:0] OP_EXTENDED = 6'h1f;
  localparam logic [8:0] XO_ADD_MINUS_ONE = 9'h0ea;
  localparam logic [IDX_W-1:0] ZERO_REG = 5'h00;

  // ----------------------------------------
  // Constant operands
  // ----------------------------------------
  localparam logic [HALF_W-1:0] LOW_HALF_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_ONES = 32'hffff_ffff;
  localparam logic [DATA_W-1:0] DATA_ZERO = 64'h0000_0000_0000_0000;
  localparam logic [DATA_W-1:0] DATA_ONES = 64'hffff_ffff_ffff_ffff;

  // ----------------------------------------
  // Register port map, word indexes
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] REG_GPR_LAST = 8'h1f;
  localparam logic [ADDR_W-1:0] REG_FLAGS = 8'h20;
  localparam logic [ADDR_W-1:0] REG_IRQ_STATUS = 8'h21;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h22;
  localparam logic [ADDR_W-1:0] REG_MODE = 8'h23;

  // ----------------------------------------
  // Interrupt event bits
  // ----------------------------------------
  localparam int unsigned EV_OVERFLOW = 0;
  localparam int unsigned EV_ILLEGAL = 1;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;
  localparam logic MODE_RESET = 1'b0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [5:0] primary;
    logic [4:0] target_reg_field;
    logic [4:0] base_reg_field;
    logic [4:0] spare;
    logic oe;
    logic [8:0] xo;
    logic record_bit;
  } instr_fields_t;

  // Condition field 0 order: negative, positive, zero, summary copy
  typedef struct packed {
    logic negative_flag;
    logic positive_flag;
    logic zero_flag;
    logic so_copy;
  } cr0_t;

  typedef struct packed {
    cr0_t cr0;
    logic summary_overflow;
    logic overflow_flag;
    logic carry_flag;
  } flags_t;

  localparam flags_t FLAGS_RESET = 7'h00;

endpackage

// File: sim/add_shifted_and_minus_one_extend_tb.sv
`timescale 1ns/1ps
module add_shifted_and_minus_one_extend_tb;
  // ----------------
  // Signals
  // ----------------
  logic clk, rst, req, bus_we, bus_re, instr_valid, wb_valid, irq;
  logic [31:0] req_word, instr_word;
  logic [7:0] bus_addr;
  logic [63:0] bus_wdata, bus_rdata, wb_data, rd_val;
  logic [4:0] wb_index;
  alu_pkg::flags_t flags;
  int failures = 0;
  int checked = 0;
  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  instr_source i_instr_source (.clk(clk), .rst(rst), .req(req), .req_word(req_word),
    .instr_valid(instr_valid), .instr_word(instr_word));
  add_shifted_and_minus_one_extend i_add_shifted_and_minus_one_extend (.clk(clk), .rst(rst),
    .instr_valid(instr_valid), .instr_word(instr_word), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_we(bus_we), .bus_re(bus_re), .bus_rdata(bus_rdata),
    .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data), .flags(flags), .irq(irq));
  // ----------------
  // Helpers
  // ----------------
  task automatic wrap_up;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [63:0] d);
    @(posedge clk);
    bus_we <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_we <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    bus_re <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_re <= 1'b0;
    #1 rd_val = bus_rdata;
  endtask
  task automatic issue(input logic [31:0] w);
    @(posedge clk);
    req <= 1'b1;
    req_word <= w;
    @(posedge clk);
    req <= 1'b0;
  endtask
  // Writeback lands exactly one cycle after the block takes the word
  task automatic exec(input logic [31:0] w, input logic [4:0] idx, input logic [63:0] d,
    input logic [6:0] f);
    issue(w);
    @(posedge clk);
    #1;
    check("wb_valid", 64'h1, {63'h0, wb_valid});
    check("wb_index", {59'h0, idx}, {59'h0, wb_index});
    check("wb_data", d, wb_data);
    check("flags", {57'h0, f}, {57'h0, flags});
  endtask
  function automatic logic [31:0] shifted(input logic [4:0] t, b, input logic [15:0] imm);
    return {alu_pkg::OP_ADD_SHIFTED, t, b, imm};
  endfunction
  function automatic logic [31:0] minus_one(input logic [4:0] t, s, input logic oe, rc);
    return {alu_pkg::OP_EXTENDED, t, s, 5'h00, oe, alu_pkg::XO_ADD_MINUS_ONE, rc};
  endfunction
  // ----------------
  // Scenarios
  // ----------------
  task automatic t_reset_values;
    check("flags port", 64'h0, {57'h0, flags});
    rd(8'h22);
    check("mask", 64'h0, rd_val);
    rd(8'h23);
    check("mode", 64'h0, rd_val);
  endtask
  task automatic t_shifted_add;
    wr(8'h06, 64'h4000);
    exec(shifted(5'h07, 5'h06, 16'h0011), 5'h07, 64'h0011_4000, 7'h00);
    wr(8'h00, 64'h1234);
    exec(shifted(5'h03, 5'h00, 16'h8000), 5'h03, 64'h8000_0000, 7'h00);
  endtask
  // Overflow, then a clean add that must not clear summary, then a zero result
  task automatic t_minus_one_forms;
    wr(8'h04, 64'h8000_0000);
    exec(minus_one(5'h06, 5'h04, 1'b1, 1'b1), 5'h06, 64'h7fff_ffff, 7'h2f);
    rd(8'h06);
    check("gpr6", 64'h7fff_ffff, rd_val);
    wr(8'h04, 64'h9000_3000);
    exec(minus_one(5'h06, 5'h04, 1'b1, 1'b0), 5'h06, 64'h9000_3000, 7'h2d);
    wr(8'h05, 64'h0);
    exec(minus_one(5'h08, 5'h05, 1'b0, 1'b1), 5'h08, 64'h0, 7'h1d);
  endtask
  task automatic t_irq_path;
    check("irq masked", 64'h0, {63'h0, irq});
    wr(8'h22, 64'h3);
    repeat (2) @(posedge clk);
    #1 check("irq on", 64'h1, {63'h0, irq});
    issue(32'h0000_0000);
    repeat (2) @(posedge clk);
    rd(8'h21);
    check("status", 64'h3, rd_val);
    wr(8'h21, 64'h1);
    wr(8'h21, 64'h2);
    repeat (2) @(posedge clk);
    #1 check("irq off", 64'h0, {63'h0, irq});
    rd(8'h40);
    check("unmapped", 64'h0, rd_val);
  endtask
  // Wide mode: sign-extended immediate, then full-width sum with carry out of bit 63
  task automatic t_wide_mode;
    wr(8'h23, 64'h1);
    exec(shifted(5'h03, 5'h00, 16'h8000), 5'h03, 64'hffff_ffff_8000_0000, 7'h1d);
    wr(8'h20, 64'h1c);
    wr(8'h09, 64'h1_0000_0000);
    exec(minus_one(5'h0a, 5'h09, 1'b0, 1'b1), 5'h0a, 64'h0000_0000_ffff_ffff, 7'h4d);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    req = 1'b0;
    req_word = 32'h0;
    bus_we = 1'b0;
    bus_re = 1'b0;
    bus_addr = 8'h00;
    bus_wdata = 64'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_shifted_add();
    t_minus_one_forms();
    t_irq_path();
    t_wide_mode();
    wrap_up();
  end
  // Watchdog, far beyond the roughly 64 cycles the run needs
  initial begin
    #12000;
    failures++;
    wrap_up();
  end
endmodule
bind add_shifted_and_minus_one_extend add_shifted_props i_add_shifted_props (.clk(clk),
  .rst(rst), .instr_valid(instr_valid), .instr_word(instr_word), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata),
  .bus_we(bus_we), .wb_valid(wb_valid), .wb_index(wb_index), .wb_data(wb_data),
  .flags(flags));

// File: sim/add_shifted_props.sv
`timescale 1ns/1ps
module add_shifted_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [7:0] bus_addr,
  input wire logic [63:0] bus_wdata,
  input wire logic bus_we,
  input wire logic wb_valid,
  input wire logic [4:0] wb_index,
  input wire logic [63:0] wb_data,
  input wire alu_pkg::flags_t flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------
  // Decode of the issued word
  // ----------------
  wire is_shift = instr_valid && instr_word[31:26] == alu_pkg::OP_ADD_SHIFTED;
  wire is_ext = instr_valid && instr_word[31:26] == alu_pkg::OP_EXTENDED
    && instr_word[9:1] == alu_pkg::XO_ADD_MINUS_ONE;
  wire flag_wr = bus_we && bus_addr == alu_pkg::REG_FLAGS;
  // ----------------
  // Shadow of the general registers, from bus writes and writebacks
  // ----------------
  logic [63:0] shadow [32];
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 32; i++) begin
        shadow[i] <= 64'h0;
      end
    end else begin
      if (wb_valid) begin
        shadow[wb_index] <= wb_data;
      end
      // A bus write one cycle after an issue is the later one, so it wins
      if (bus_we && bus_addr <= 8'h1f) begin
        shadow[bus_addr[4:0]] <= bus_wdata;
      end
    end
  end
  // Writeback still on the port is not yet in the shadow: bypass it
  wire [4:0] base_idx = instr_word[20:16];
  wire [15:0] base_low = (base_idx == 5'h00) ? 16'h0000
    : (wb_valid && wb_index == base_idx) ? wb_data[15:0] : shadow[base_idx][15:0];
  // Bus writes to the flags word are excluded, they may legally move flags
  sequence s_quiet_shift; is_shift && !flag_wr; endsequence
  sequence s_ext_no_oe; is_ext && !instr_word[10] && !flag_wr; endsequence
  sequence s_ext_no_rc; is_ext && !instr_word[0] && !flag_wr; endsequence
  // ----------------
  // Properties
  // ----------------
  a_wb_follows_issue: assert property ((is_shift || is_ext) |=>
    wb_valid && wb_index == $past(instr_word[25:21])) else $error("no writeback");
  a_illegal_no_wb: assert property (instr_valid && !is_shift && !is_ext |=>
    !wb_valid) else $error("writeback on unknown opcode");
  a_shift_low_half: assert property (is_shift |=> wb_data[15:0] == $past(base_low))
    else $error("shifted add low half wrong");
  a_shift_zero_base: assert property (is_shift && instr_word[20:16] == 5'h00 |=>
    wb_data[31:0] == {$past(instr_word[15:0]), 16'h0000}) else $error("zero base wrong");
  a_shift_flags_kept: assert property (s_quiet_shift |=> $stable(flags))
    else $error("shifted add moved flags");
  a_no_oe_keeps: assert property (s_ext_no_oe |=> $stable(flags.overflow_flag)
    && $stable(flags.summary_overflow)) else $error("overflow moved without enable");
  a_no_rc_keeps: assert property (s_ext_no_rc |=> $stable(flags.cr0))
    else $error("condition field moved without record");
  a_cr0_so_copy: assert property (is_ext && instr_word[0] |=>
    flags.cr0.so_copy == flags.summary_overflow) else $error("summary copy wrong");
  a_cr0_one_hot: assert property (is_ext && instr_word[0] |=>
    $onehot({flags.cr0.negative_flag, flags.cr0.positive_flag, flags.cr0.zero_flag}))
    else $error("compare bits not one hot");
  a_so_sticky: assert property (flags.summary_overflow && !flag_wr |=>
    flags.summary_overflow) else $error("summary overflow dropped");
endmodule

// File: sim/instr_source.sv
`timescale 1ns/1ps
module instr_source (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from the bench
  input wire logic req,
  input wire logic [31:0] req_word,
  // Issue toward the block
  output logic instr_valid,
  output logic [31:0] instr_word
);
  // One issue per request; idle word scrambled so nothing leans on a held value
  always_ff @(posedge clk) begin
    instr_valid <= rst ? 1'b0 : req;
    instr_word <= req ? req_word : ~instr_word;
  end
endmodule
